// ---- rtl/rsq_top.sv ----
`timescale 1ns/100ps
`include "rsq_consts.svh"
// How it works
// - Free start, same mux: result readable in the next frame.
// - Free start, mux changed: settle first, result in second frame.
// - A second start mode begins conversion on a trigger pin rise.
// - In trigger mode a start bit 0 to 1 only arms the converter.
// - Trigger mode also settles when mux changes with the start.
// - Trigger rises during settling are ignored.
// - After settling the first trigger rise starts the conversion.
// - On completion the result goes into register 11.
// - Completion raises interrupts enabled by bits in registers 2, 3.
// - Result reads zero from start or arm until completion.
// - Valid flag drops at start, rises when result is stored.
// - Settling and conversion count rising edges of the link clock pin.
// - Read data returns in the same frame as the read request.
module rsq_top
    import rsq_pkg::*;
#(
    parameter int CONV_CYC = `RSQ_CONV_LINK_CYC,
    parameter int SETTLE_CYC = `RSQ_SETTLE_LINK_CYC
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic LINK_CLOCK_PIN,
    input wire logic FRAME_SYNC_PIN,
    input wire logic LINK_DIN_PIN,
    input wire logic CONV_TRIGGER_PIN,
    input wire logic [`RSQ_RES_W-1:0] CONV_DATA_IN,
    output logic LINK_DOUT_PIN,
    output logic LINK_DOUT_OE,
    output logic [`RSQ_MUX_W-1:0] CONV_MUX_SEL,
    output logic CONV_HOLD,
    output logic CONV_DONE_RISE_IRQ,
    output logic CONV_DONE_FALL_IRQ
);
    logic [3:0] pin_lvl;
    logic [3:0] pin_rise;
    logic [3:0] pin_fall;
    logic [`RSQ_RES_W-1:0] adc_lvl;
    logic lk_rise;
    logic lk_fall;
    logic sync_lvl;
    logic din_lvl;
    logic trig_rise;
    logic [6:0] bit_cnt_ff;
    logic [6:0] nxt_bit;
    logic [15:0] rx_ff;
    logic [3:0] addr_ff;
    logic wr_ff;
    logic [15:0] rd_data_ff;
    logic dout_ff;
    logic oe_ff;
    logic wr_commit;
    logic [15:0] wdata;
    logic irq_rise_en_ff;
    logic irq_fall_en_ff;
    logic start_ff;
    logic sync_mode_ff;
    logic [`RSQ_MUX_W-1:0] mux_ff;
    logic [`RSQ_MUX_W-1:0] new_mux;
    logic start_evt;
    logic mux_chg;
    logic new_sync;
    rsq_state_t state_ff;
    logic trig_mode_ff;
    logic [6:0] seq_cnt_ff;
    logic done;
    logic [`RSQ_RES_W-1:0] result_ff;
    logic valid_ff;
    logic hold_ff;
    logic rise_irq_ff;
    logic fall_irq_ff;

    // Pin synchronisers: link clock, frame sync, data in, trigger
    rsq_sync #(.W(4)) u_pins (
        .clk(CLK),
        .reset_n(RESET_N),
        .pin_in({CONV_TRIGGER_PIN, LINK_DIN_PIN, FRAME_SYNC_PIN,
                 LINK_CLOCK_PIN}),
        .level(pin_lvl),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // Comparator result from the analogue side
    rsq_sync #(.W(`RSQ_RES_W)) u_data (
        .clk(CLK),
        .reset_n(RESET_N),
        .pin_in(CONV_DATA_IN),
        .level(adc_lvl),
        .rise(),
        .fall()
    );

    assign lk_rise = pin_rise[0];
    assign lk_fall = pin_fall[0];
    assign sync_lvl = pin_lvl[1];
    assign din_lvl = pin_lvl[2];
    assign trig_rise = pin_rise[3];

    // Register read decode
    function automatic logic [15:0] read_reg(input logic [3:0] a);
        logic [15:0] d;
        d = 16'h0000;
        case (a)
            `RSQ_REG_IRQ_RISE: d[`RSQ_IRQ_CONV_BIT] = irq_rise_en_ff;
            `RSQ_REG_IRQ_FALL: d[`RSQ_IRQ_CONV_BIT] = irq_fall_en_ff;
            `RSQ_REG_CTRL: begin
                d[`RSQ_CTRL_START_BIT] = start_ff;
                d[`RSQ_CTRL_SYNC_BIT] = sync_mode_ff;
                d[`RSQ_CTRL_MUX_LSB +: `RSQ_MUX_W] = mux_ff;
            end
            `RSQ_REG_RESULT: begin
                d[`RSQ_RES_VALID_BIT] = valid_ff;
                d[`RSQ_RES_W-1:0] = result_ff;
            end
            default: d = 16'h0000;
        endcase
        return d;
    endfunction

    // Index of the bit that the coming rising link edge opens
    assign nxt_bit = sync_lvl ? 7'h00 :
        ((bit_cnt_ff < `RSQ_BIT_IDLE) ? bit_cnt_ff + 7'h01 : bit_cnt_ff);

    // Frame bit counter and output bit, moved on rising link edges
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            bit_cnt_ff <= `RSQ_BIT_IDLE;
            dout_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else if (lk_rise) begin
            bit_cnt_ff <= nxt_bit;
            oe_ff <= (nxt_bit < `RSQ_BIT_IDLE);
            if (nxt_bit >= `RSQ_BIT_DATA_FIRST && nxt_bit < `RSQ_BIT_IDLE)
                dout_ff <= rd_data_ff[4'(`RSQ_BIT_LAST - nxt_bit)];
            else
                dout_ff <= 1'b0;
        end
    end

    // Input bits sampled on falling link edges; read data latched early
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            rx_ff <= 16'h0000;
            addr_ff <= 4'h0;
            wr_ff <= 1'b0;
            rd_data_ff <= 16'h0000;
        end else if (lk_fall && bit_cnt_ff < `RSQ_BIT_IDLE) begin
            rx_ff <= {rx_ff[14:0], din_lvl};
            if (bit_cnt_ff == `RSQ_BIT_ADDR_LAST)
                addr_ff <= {rx_ff[2:0], din_lvl};
            if (bit_cnt_ff == `RSQ_BIT_WRITE) begin
                wr_ff <= din_lvl;
                rd_data_ff <= read_reg(addr_ff);
            end
        end
    end

    // Write takes effect after the last data bit of the frame
    assign wr_commit = lk_fall && wr_ff && (bit_cnt_ff == `RSQ_BIT_LAST);
    assign wdata = {rx_ff[14:0], din_lvl};
    assign new_mux = wdata[`RSQ_CTRL_MUX_LSB +: `RSQ_MUX_W];
    assign new_sync = wdata[`RSQ_CTRL_SYNC_BIT];
    assign start_evt = wr_commit && (addr_ff == `RSQ_REG_CTRL) &&
        wdata[`RSQ_CTRL_START_BIT] && !start_ff;
    assign mux_chg = (new_mux != mux_ff);

    // Writable control and interrupt enable bits
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            irq_rise_en_ff <= 1'b0;
            irq_fall_en_ff <= 1'b0;
            start_ff <= 1'b0;
            sync_mode_ff <= 1'b0;
            mux_ff <= `RSQ_MUX_RST;
        end else if (wr_commit) begin
            case (addr_ff)
                `RSQ_REG_IRQ_RISE: irq_rise_en_ff <= wdata[`RSQ_IRQ_CONV_BIT];
                `RSQ_REG_IRQ_FALL: irq_fall_en_ff <= wdata[`RSQ_IRQ_CONV_BIT];
                `RSQ_REG_CTRL: begin
                    start_ff <= wdata[`RSQ_CTRL_START_BIT];
                    sync_mode_ff <= new_sync;
                    mux_ff <= new_mux;
                end
                default: ;
            endcase
        end
    end

    assign done = (state_ff == RSQ_CONVERT) && lk_rise &&
        (seq_cnt_ff == 7'(CONV_CYC - 1));

    // Start/stop sequencer, counting rising link edges
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            state_ff <= RSQ_IDLE;
            trig_mode_ff <= 1'b0;
            seq_cnt_ff <= 7'h00;
        end else if (start_evt) begin
            trig_mode_ff <= new_sync;
            seq_cnt_ff <= 7'h00;
            if (mux_chg)
                state_ff <= RSQ_SETTLE;
            else if (new_sync)
                state_ff <= RSQ_WAIT_TRIG;
            else
                state_ff <= RSQ_CONVERT;
        end else begin
            unique case (state_ff)
                RSQ_IDLE: ;
                RSQ_SETTLE: begin
                    // Trigger edges are not looked at here
                    if (lk_rise) begin
                        if (seq_cnt_ff == 7'(SETTLE_CYC - 1)) begin
                            seq_cnt_ff <= 7'h00;
                            state_ff <= trig_mode_ff ? RSQ_WAIT_TRIG
                                                     : RSQ_CONVERT;
                        end else begin
                            seq_cnt_ff <= seq_cnt_ff + 7'h01;
                        end
                    end
                end
                RSQ_WAIT_TRIG: begin
                    if (trig_rise)
                        state_ff <= RSQ_CONVERT;
                end
                RSQ_CONVERT: begin
                    if (done) begin
                        seq_cnt_ff <= 7'h00;
                        state_ff <= RSQ_IDLE;
                    end else if (lk_rise) begin
                        seq_cnt_ff <= seq_cnt_ff + 7'h01;
                    end
                end
            endcase
        end
    end

    // Result register: zero while busy, loaded at completion
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            result_ff <= `RSQ_RESULT_RST;
            valid_ff <= 1'b0;
        end else if (start_evt) begin
            result_ff <= `RSQ_RESULT_RST;
            valid_ff <= 1'b0;
        end else if (done) begin
            result_ff <= adc_lvl;
            valid_ff <= 1'b1;
        end
    end

    // Registered pin and analogue side outputs, completion pulses
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            hold_ff <= 1'b0;
            rise_irq_ff <= 1'b0;
            fall_irq_ff <= 1'b0;
        end else begin
            hold_ff <= (state_ff == RSQ_CONVERT);
            rise_irq_ff <= done && irq_rise_en_ff;
            fall_irq_ff <= done && irq_fall_en_ff;
        end
    end

    assign LINK_DOUT_PIN = dout_ff;
    assign LINK_DOUT_OE = oe_ff;
    assign CONV_MUX_SEL = mux_ff;
    assign CONV_HOLD = hold_ff;
    assign CONV_DONE_RISE_IRQ = rise_irq_ff;
    assign CONV_DONE_FALL_IRQ = fall_irq_ff;

    // Checks on the sequencer and register contents
    property p_valid_drop;
        @(posedge CLK) disable iff (!RESET_N)
        start_evt |=> !valid_ff;
    endproperty
    a_valid_drop: assert property (p_valid_drop)
        else $error("valid flag not cleared at start");

    property p_result_zero;
        @(posedge CLK) disable iff (!RESET_N)
        start_evt |=> (result_ff == `RSQ_RESULT_RST) && !valid_ff;
    endproperty
    a_result_zero: assert property (p_result_zero)
        else $error("result not zero after start");

    property p_store;
        @(posedge CLK) disable iff (!RESET_N)
        done && !start_evt |=> valid_ff && result_ff == $past(adc_lvl);
    endproperty
    a_store: assert property (p_store)
        else $error("result not stored at completion");

    property p_settle_ignore;
        @(posedge CLK) disable iff (!RESET_N)
        state_ff == RSQ_SETTLE && trig_rise && !start_evt && !lk_rise
            |=> state_ff == RSQ_SETTLE;
    endproperty
    a_settle_ignore: assert property (p_settle_ignore)
        else $error("trigger acted during settling");

    property p_trig_start;
        @(posedge CLK) disable iff (!RESET_N)
        state_ff == RSQ_WAIT_TRIG && trig_rise && !start_evt
            |=> state_ff == RSQ_CONVERT ##1 hold_ff;
    endproperty
    a_trig_start: assert property (p_trig_start)
        else $error("trigger rise did not start conversion");

    property p_arm;
        @(posedge CLK) disable iff (!RESET_N)
        start_evt && new_sync && !mux_chg |=> state_ff == RSQ_WAIT_TRIG;
    endproperty
    a_arm: assert property (p_arm)
        else $error("trigger mode start did not arm");

    property p_free_start;
        @(posedge CLK) disable iff (!RESET_N)
        start_evt && !new_sync && !mux_chg |=> state_ff == RSQ_CONVERT;
    endproperty
    a_free_start: assert property (p_free_start)
        else $error("free start did not convert at once");

    property p_settle;
        @(posedge CLK) disable iff (!RESET_N)
        start_evt && mux_chg |=> state_ff == RSQ_SETTLE && seq_cnt_ff == 0;
    endproperty
    a_settle: assert property (p_settle)
        else $error("mux change did not settle");

    property p_irq;
        @(posedge CLK) disable iff (!RESET_N)
        done && irq_rise_en_ff |=> CONV_DONE_RISE_IRQ ##1 !CONV_DONE_RISE_IRQ;
    endproperty
    a_irq: assert property (p_irq)
        else $error("completion interrupt missing");

    property p_link_paced;
        @(posedge CLK) disable iff (!RESET_N)
        state_ff == RSQ_CONVERT && !lk_rise && !start_evt
            |=> $stable(seq_cnt_ff);
    endproperty
    a_link_paced: assert property (p_link_paced)
        else $error("conversion count moved without link edge");

    property p_read_same;
        @(posedge CLK) disable iff (!RESET_N)
        lk_fall && bit_cnt_ff == `RSQ_BIT_WRITE && addr_ff == `RSQ_REG_RESULT
            |=> rd_data_ff[`RSQ_RES_W-1:0] == $past(result_ff);
    endproperty
    a_read_same: assert property (p_read_same)
        else $error("read data not latched in frame");
endmodule

// ---- rtl/rsq_consts.svh ----
`ifndef RSQ_CONSTS_SVH
`define RSQ_CONSTS_SVH

// Control register numbers on the frame serial link
`define RSQ_REG_IRQ_RISE 4'h2
`define RSQ_REG_IRQ_FALL 4'h3
`define RSQ_REG_CTRL 4'hA
`define RSQ_REG_RESULT 4'hB

// Field positions
`define RSQ_IRQ_CONV_BIT 11
`define RSQ_CTRL_START_BIT 15
`define RSQ_CTRL_SYNC_BIT 0
`define RSQ_CTRL_MUX_LSB 2
`define RSQ_MUX_W 3
`define RSQ_RES_VALID_BIT 15
`define RSQ_RES_W 10

// Frame bit positions, bit 0 first on the wire
`define RSQ_BIT_ADDR_LAST 7'h14
`define RSQ_BIT_WRITE 7'h15
`define RSQ_BIT_DATA_FIRST 7'h30
`define RSQ_BIT_LAST 7'h3F
`define RSQ_BIT_IDLE 7'h40

// Reset values
`define RSQ_RESULT_RST 10'h000
`define RSQ_MUX_RST 3'h0

// Timing in link clock cycles
`define RSQ_CONV_LINK_CYC 16
`define RSQ_SETTLE_LINK_CYC 64

`endif

// ---- rtl/rsq_pkg.sv ----
package rsq_pkg;
    // Sequencer states
    typedef enum logic [1:0] {
        RSQ_IDLE = 2'b00,
        RSQ_SETTLE = 2'b01,
        RSQ_WAIT_TRIG = 2'b10,
        RSQ_CONVERT = 2'b11
    } rsq_state_t;
endpackage

// ---- rtl/rsq_sync.sv ----
`timescale 1ns/100ps
module rsq_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] stage1_ff;
    logic [W-1:0] stage2_ff;
    logic [W-1:0] prev_ff;

    // Two flops against metastability, third one for edge finding
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
            prev_ff <= '0;
        end else begin
            stage1_ff <= pin_in;
            stage2_ff <= stage1_ff;
            prev_ff <= stage2_ff;
        end
    end

    // Edges are seen from the second stage onward only
    assign level = stage2_ff;
    assign rise = stage2_ff & ~prev_ff;
    assign fall = ~stage2_ff & prev_ff;
endmodule

// ---- sim/rsq_link_model.sv ----
`timescale 1ns/100ps
// Controller end of the frame link: drives clock, sync and data in
module rsq_link_model (
    input wire logic dout,
    input wire logic dout_oe,
    output logic link_clk,
    output logic sync,
    output logic din,
    output int oe_errs
);
    initial begin
        link_clk = 1'b0;
        sync = 1'b0;
        din = 1'b0;
        oe_errs = 0;
    end

    // One 64-bit register frame plus the idle rise; clock parks low after
    task automatic xfer(input logic [3:0] addr, input logic wr,
                        input logic [15:0] wdata, output logic [15:0] rdata);
        logic [63:0] fr;
        fr = '0;
        for (int k = 0; k < 4; k++) begin
            fr[17+k] = addr[3-k];
        end
        fr[21] = wr;
        for (int k = 0; k < 16; k++) begin
            fr[48+k] = wdata[15-k];
        end
        #13;
        sync = 1'b1;
        #200;
        for (int i = 0; i < 64; i++) begin
            link_clk = 1'b1;
            din = fr[i];
            #200;
            sync = 1'b0;
            link_clk = 1'b0;
            #200;
            // Out bit is settled just before the next rise
            if (dout_oe !== 1'b1) oe_errs++;
            if (i >= 48) rdata[63-i] = dout;
        end
        link_clk = 1'b1;
        din = ~din; // Released line shows no stale value
        #200;
        link_clk = 1'b0;
        #200;
        if (dout_oe !== 1'b0) oe_errs++;
    endtask
endmodule

// ---- sim/rsq_top_test.sv ----
`timescale 1ns/100ps
`include "rsq_consts.svh"
`define CHK(nm, exp, got) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("mismatch %s expected %h seen %h", nm, exp, got); \
    end \
end
module rsq_top_test;
    logic clk;
    logic reset_n;
    logic link_clk;
    logic sync;
    logic din;
    logic trig;
    logic [`RSQ_RES_W-1:0] conv_data;
    logic dout;
    logic dout_oe;
    logic [`RSQ_MUX_W-1:0] mux_sel;
    logic hold;
    logic irq_r;
    logic irq_f;
    logic [15:0] rd;
    int oe_errs;
    int n_mismatch;
    int comparisons;
    int n_rise;
    int n_fall;
    int cyc;

    rsq_top uut (
        .CLK(clk),
        .RESET_N(reset_n),
        .LINK_CLOCK_PIN(link_clk),
        .FRAME_SYNC_PIN(sync),
        .LINK_DIN_PIN(din),
        .CONV_TRIGGER_PIN(trig),
        .CONV_DATA_IN(conv_data),
        .LINK_DOUT_PIN(dout),
        .LINK_DOUT_OE(dout_oe),
        .CONV_MUX_SEL(mux_sel),
        .CONV_HOLD(hold),
        .CONV_DONE_RISE_IRQ(irq_r),
        .CONV_DONE_FALL_IRQ(irq_f)
    );

    rsq_link_model lnk (
        .dout(dout),
        .dout_oe(dout_oe),
        .link_clk(link_clk),
        .sync(sync),
        .din(din),
        .oe_errs(oe_errs)
    );

    // System clock, 50 ns period
    initial clk = 1'b0;
    always #25 clk = ~clk;

    // Interrupt pulse counters and hang guard
    always @(posedge clk) begin
        if (irq_r === 1'b1) n_rise++;
        if (irq_f === 1'b1) n_fall++;
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        lnk.xfer(a, 1'b1, d, rd);
    endtask

    task automatic chk_reg(input logic [3:0] a, input logic [15:0] e);
        lnk.xfer(a, 1'b0, 16'h0000, rd);
        `CHK("reg read", e, rd)
    endtask

    function automatic logic [15:0] ctrl(logic st, logic sy, logic [2:0] m);
        return {st, 10'h000, m, 1'b0, sy};
    endfunction

    task automatic set_data(input logic [9:0] v);
        @(negedge clk);
        conv_data = v;
    endtask

    task automatic pulse_trig();
        @(negedge clk);
        trig = 1'b1;
        repeat (8) @(negedge clk);
        trig = 1'b0;
        repeat (8) @(negedge clk);
    endtask

    // Free start with unchanged mux, interrupts off
    task automatic t_free_same();
        chk_reg(`RSQ_REG_RESULT, 16'h0000);
        wr(`RSQ_REG_CTRL, ctrl(1'b0, 1'b0, 3'h1));
        `CHK("mux", 3'h1, mux_sel)
        set_data(10'h2A5);
        wr(`RSQ_REG_CTRL, ctrl(1'b1, 1'b0, 3'h1));
        chk_reg(`RSQ_REG_RESULT, 16'h82A5);
        `CHK("irq off", 0, n_rise + n_fall)
        set_data(10'h15A);
        wr(`RSQ_REG_CTRL, ctrl(1'b1, 1'b0, 3'h1));
        chk_reg(`RSQ_REG_RESULT, 16'h82A5);
        chk_reg(4'h7, 16'h0000);
        $display("test free_same done");
    endtask

    // Free start with mux change: settle, result two frames on
    task automatic t_free_mux();
        wr(`RSQ_REG_IRQ_RISE, 16'h0800);
        n_rise = 0;
        n_fall = 0;
        wr(`RSQ_REG_CTRL, ctrl(1'b0, 1'b0, 3'h1));
        set_data(10'h3C3);
        wr(`RSQ_REG_CTRL, ctrl(1'b1, 1'b0, 3'h6));
        chk_reg(`RSQ_REG_RESULT, 16'h0000);
        `CHK("mux", 3'h6, mux_sel)
        chk_reg(`RSQ_REG_RESULT, 16'h83C3);
        `CHK("rise irq", 1, n_rise)
        `CHK("fall irq", 0, n_fall)
        $display("test free_mux done");
    endtask

    // Trigger mode, same mux: arm only, convert on trigger rise
    task automatic t_trig_arm();
        wr(`RSQ_REG_IRQ_FALL, 16'h0800);
        n_rise = 0;
        n_fall = 0;
        wr(`RSQ_REG_CTRL, ctrl(1'b0, 1'b1, 3'h6));
        set_data(10'h0F0);
        wr(`RSQ_REG_CTRL, ctrl(1'b1, 1'b1, 3'h6));
        chk_reg(`RSQ_REG_RESULT, 16'h0000);
        `CHK("early irq", 0, n_rise + n_fall)
        `CHK("hold armed", 1'b0, hold)
        pulse_trig();
        `CHK("hold on trigger", 1'b1, hold)
        chk_reg(`RSQ_REG_RESULT, 16'h80F0);
        `CHK("rise irq", 1, n_rise)
        `CHK("fall irq", 1, n_fall)
        $display("test trig_arm done");
    endtask

    // Trigger mode, mux change: trigger during settling is ignored
    task automatic t_trig_settle();
        wr(`RSQ_REG_CTRL, ctrl(1'b0, 1'b1, 3'h6));
        set_data(10'h00F);
        wr(`RSQ_REG_CTRL, ctrl(1'b1, 1'b1, 3'h2));
        pulse_trig();
        `CHK("hold settling", 1'b0, hold)
        chk_reg(`RSQ_REG_RESULT, 16'h0000);
        chk_reg(`RSQ_REG_RESULT, 16'h0000);
        pulse_trig();
        chk_reg(`RSQ_REG_RESULT, 16'h800F);
        $display("test trig_settle done");
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Reset, then the scenarios in order
    initial begin
        reset_n = 1'b0;
        trig = 1'b0;
        conv_data = 10'h000;
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        t_free_same();
        t_free_mux();
        t_trig_arm();
        t_trig_settle();
        `CHK("frame enable", 0, oe_errs)
        test_done();
    end
endmodule
